/* design/wta_pkg.sv */
package wta_pkg;

  // Crystal and prescaler
  localparam int unsigned XTAL_FREQ_HZ = 32768;         // 32.768 kHz crystal
  localparam int unsigned TICK_FREQ_HZ = 1;             // Seconds tick rate
  localparam int unsigned XTAL_DIV     = XTAL_FREQ_HZ / TICK_FREQ_HZ;
  localparam int unsigned PRE_W        = 16;            // Prescaler width

  // Counter wrap points
  localparam logic [5:0] SEC_LAST  = 6'h3B;             // 59
  localparam logic [5:0] MIN_LAST  = 6'h3B;             // 59
  localparam logic [4:0] HOUR_LAST = 5'h17;             // 23

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_TIME  = 8'h04;
  localparam logic [7:0] OFS_ALM0  = 8'h08;
  localparam logic [7:0] OFS_ALM1  = 8'h0C;
  localparam logic [7:0] OFS_SWCH  = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_MASK  = 8'h18;
  localparam logic [7:0] OFS_WAKE  = 8'h1C;

  // Time word field positions
  localparam int unsigned POS_SEC  = 0;
  localparam int unsigned POS_MIN  = 8;
  localparam int unsigned POS_HOUR = 16;
  localparam int unsigned POS_DAY  = 24;

  // Control bit positions
  localparam int unsigned CTL_ALM0_EN = 0;
  localparam int unsigned CTL_ALM1_EN = 1;
  localparam int unsigned CTL_SW_EN   = 2;

  // Event bit positions in status, mask and wake registers
  localparam int unsigned EV_SEC  = 0;
  localparam int unsigned EV_MIN  = 1;
  localparam int unsigned EV_DAY  = 2;
  localparam int unsigned EV_ALM0 = 3;
  localparam int unsigned EV_ALM1 = 4;
  localparam int unsigned EV_SWU  = 5;
  localparam int unsigned EV_N    = 6;

  // Reset values
  localparam logic [2:0]      RST_CTRL = 3'h0;
  localparam logic [EV_N-1:0] RST_EV   = 6'h00;
  localparam logic [15:0]     RST_SW   = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Time of day and day count
  typedef struct packed {
    logic [7:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } wta_time_t;

  // Master to slave AXI4-Lite signals
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } wta_axi_req_t;

  // Slave to master AXI4-Lite signals
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wta_axi_rsp_t;

endpackage

/* design/wta_rtc.sv */
module wta_rtc
  import wta_pkg::*;
#(
  parameter int unsigned XTAL_DIV_P = XTAL_DIV  // Crystal edges per second
)
(
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   xtal_in,
  input  wta_axi_req_t axi_req,
  output wta_axi_rsp_t axi_rsp,
  output logic        irq,
  output logic        wake_req
);

  // All state of the block
  typedef struct packed {
    logic [PRE_W-1:0] pre;      // Crystal edge count
    wta_time_t        tm;       // Running time
    wta_time_t        alm0;     // Time of day alarm
    wta_time_t        alm1;     // Day and time alarm
    logic [15:0]      sw;       // Stopwatch minutes
    logic [2:0]       ctrl;     // Alarm and stopwatch enables
    logic [EV_N-1:0]  stat;     // Sticky event flags
    logic [EV_N-1:0]  mask;     // Interrupt enables
    logic [EV_N-1:0]  wake;     // Wakeup enables
    logic             aw_got;   // Write address held
    logic [7:0]       awaddr;   // Held write address
    logic             aw_bad;   // Held address out of range
    logic             w_got;    // Write data held
    logic [31:0]      wdata;    // Held write data
    logic [3:0]       wstrb;    // Held byte strobes
    logic             bvalid;   // Write response pending
    logic [1:0]       bresp;    // Write response code
    logic             rvalid;   // Read data pending
    logic [31:0]      rdata;    // Read data
    logic [1:0]       rresp;    // Read response code
    logic             irq;      // Interrupt output
    logic             wk;       // Wakeup output
  } wta_rtc_state_t;

  wta_rtc_state_t r_ff;   // Current state
  wta_rtc_state_t nxt_r;  // Next state

  logic      xtal_rise;   // One strobe per crystal rising edge
  logic      tick;        // Seconds tick
  logic      min_ev;      // Minute rollover
  logic      hr_roll;     // Hour rollover
  logic      day_ev;      // Day rollover
  logic      alm0_hit;    // Alarm zero match
  logic      alm1_hit;    // Alarm one match
  logic      sw_ev;       // Stopwatch underflow
  logic      tm_wr;       // Software writes time this cycle
  logic      sw_wr;       // Software writes stopwatch this cycle
  wta_time_t tn;          // Time after this tick

  // Time as a bus word
  function automatic logic [31:0] wta_tm2word(input wta_time_t t);
    logic [31:0] w;
    w = '0;
    w[POS_SEC +: 6]  = t.sec;
    w[POS_MIN +: 6]  = t.min;
    w[POS_HOUR +: 5] = t.hour;
    w[POS_DAY +: 8]  = t.day;
    return w;
  endfunction

  // Bus word back to time fields
  function automatic wta_time_t wta_word2tm(input logic [31:0] w);
    wta_time_t t;
    t.sec  = w[POS_SEC +: 6];
    t.min  = w[POS_MIN +: 6];
    t.hour = w[POS_HOUR +: 5];
    t.day  = w[POS_DAY +: 8];
    return t;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] wta_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Alarm compare; day count only joins when asked
  function automatic logic wta_match(input wta_time_t t, input wta_time_t a,
                                     input logic use_day);
    return (t.sec == a.sec) && (t.min == a.min) && (t.hour == a.hour) &&
           (!use_day || (t.day == a.day));
  endfunction

  // Crystal pin into the clock domain
  wta_xtal_sync u_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .xtal_in   (xtal_in),
    .xtal_rise (xtal_rise)
  );

  // Timekeeping, events, register bus and outputs
  always_comb begin
    logic        aw_hs;
    logic        w_hs;
    logic        do_wr;
    logic [7:0]  wa;
    logic        wbad;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [7:0]  ra;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;
    aw_hs = 1'b0;
    w_hs  = 1'b0;
    do_wr = 1'b0;
    wa    = '0;
    wbad  = 1'b0;
    wd    = '0;
    ws    = '0;
    ra    = '0;
    ev    = '0;
    clr   = '0;
    nxt_r = r_ff;
    tm_wr = 1'b0;
    sw_wr = 1'b0;

    // Prescaler counts crystal edges only, so it never depends on bus activity
    tick = xtal_rise && (r_ff.pre == PRE_W'(XTAL_DIV_P - 1));
    if (tick) begin
      nxt_r.pre = '0;
    end else if (xtal_rise) begin
      nxt_r.pre = r_ff.pre + PRE_W'(1);
    end

    // Cascade; compare with >= so an out-of-range load still wraps
    min_ev  = tick && (r_ff.tm.sec >= SEC_LAST);
    hr_roll = min_ev && (r_ff.tm.min >= MIN_LAST);
    day_ev  = hr_roll && (r_ff.tm.hour >= HOUR_LAST);
    tn = r_ff.tm;
    if (tick) begin
      tn.sec = min_ev ? 6'h00 : r_ff.tm.sec + 6'h01;
    end
    if (min_ev) begin
      tn.min = hr_roll ? 6'h00 : r_ff.tm.min + 6'h01;
    end
    if (hr_roll) begin
      tn.hour = day_ev ? 5'h00 : r_ff.tm.hour + 5'h01;
    end
    if (day_ev) begin
      tn.day = r_ff.tm.day + 8'h01;
    end
    nxt_r.tm = tn;

    // Alarms fire on the tick that makes the counters equal the alarm
    alm0_hit = tick && r_ff.ctrl[CTL_ALM0_EN] && wta_match(tn, r_ff.alm0, 1'b0);
    alm1_hit = tick && r_ff.ctrl[CTL_ALM1_EN] && wta_match(tn, r_ff.alm1, 1'b1);

    // Stopwatch steps once per minute and wraps to all ones past zero
    sw_ev = min_ev && r_ff.ctrl[CTL_SW_EN] && (r_ff.sw == 16'h0000);
    if (min_ev && r_ff.ctrl[CTL_SW_EN]) begin
      nxt_r.sw = r_ff.sw - 16'h0001;
    end

    // Event vector
    ev[EV_SEC]  = tick;
    ev[EV_MIN]  = min_ev;
    ev[EV_DAY]  = day_ev;
    ev[EV_ALM0] = alm0_hit;
    ev[EV_ALM1] = alm1_hit;
    ev[EV_SWU]  = sw_ev;

    // Write address and data channels, taken in either order
    aw_hs = axi_req.awvalid && !r_ff.aw_got && !r_ff.bvalid;
    w_hs  = axi_req.wvalid && !r_ff.w_got && !r_ff.bvalid;
    if (aw_hs) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = axi_req.awaddr[7:0];
      nxt_r.aw_bad = (axi_req.awaddr[31:8] != 24'h000000);
    end
    if (w_hs) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = axi_req.wdata;
      nxt_r.wstrb = axi_req.wstrb;
    end
    do_wr = (r_ff.aw_got || aw_hs) && (r_ff.w_got || w_hs);
    wa    = r_ff.aw_got ? r_ff.awaddr : axi_req.awaddr[7:0];
    wbad  = r_ff.aw_got ? r_ff.aw_bad : (axi_req.awaddr[31:8] != 24'h000000);
    wd    = r_ff.w_got ? r_ff.wdata : axi_req.wdata;
    ws    = r_ff.w_got ? r_ff.wstrb : axi_req.wstrb;

    // Register writes; a bus write to time or stopwatch beats the tick for that register
    if (do_wr) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got  = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp  = RESP_OKAY;
      if (wbad) begin
        nxt_r.bresp = RESP_SLVERR;
      end else if ({wa[7:2], 2'b00} == OFS_CTRL) begin
        nxt_r.ctrl = 3'(wta_merge({29'h0, r_ff.ctrl}, wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_TIME) begin
        tm_wr    = 1'b1;
        nxt_r.tm = wta_word2tm(wta_merge(wta_tm2word(r_ff.tm), wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_ALM0) begin
        nxt_r.alm0 = wta_word2tm(wta_merge(wta_tm2word(r_ff.alm0), wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_ALM1) begin
        nxt_r.alm1 = wta_word2tm(wta_merge(wta_tm2word(r_ff.alm1), wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_SWCH) begin
        sw_wr    = 1'b1;
        nxt_r.sw = 16'(wta_merge({16'h0000, r_ff.sw}, wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_STAT) begin
        clr = EV_N'(wta_merge(32'h0, wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_MASK) begin
        nxt_r.mask = EV_N'(wta_merge({26'h0, r_ff.mask}, wd, ws));
      end else if ({wa[7:2], 2'b00} == OFS_WAKE) begin
        nxt_r.wake = EV_N'(wta_merge({26'h0, r_ff.wake}, wd, ws));
      end else begin
        nxt_r.bresp = RESP_SLVERR;
      end
    end
    if (r_ff.bvalid && axi_req.bready) begin
      nxt_r.bvalid = 1'b0;
    end

    // Sticky flags: an event in the clearing cycle survives the clear
    nxt_r.stat = (r_ff.stat & ~clr) | ev;

    // Read channel; data is sampled from the current state
    if (r_ff.rvalid && axi_req.rready) begin
      nxt_r.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !r_ff.rvalid) begin
      ra           = {axi_req.araddr[7:2], 2'b00};
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp  = RESP_OKAY;
      nxt_r.rdata  = 32'h0000_0000;
      if (axi_req.araddr[31:8] != 24'h000000) begin
        nxt_r.rresp = RESP_SLVERR;
      end else if (ra == OFS_CTRL) begin
        nxt_r.rdata = {29'h0, r_ff.ctrl};
      end else if (ra == OFS_TIME) begin
        nxt_r.rdata = wta_tm2word(r_ff.tm);
      end else if (ra == OFS_ALM0) begin
        nxt_r.rdata = wta_tm2word(r_ff.alm0);
      end else if (ra == OFS_ALM1) begin
        nxt_r.rdata = wta_tm2word(r_ff.alm1);
      end else if (ra == OFS_SWCH) begin
        nxt_r.rdata = {16'h0000, r_ff.sw};
      end else if (ra == OFS_STAT) begin
        nxt_r.rdata = {26'h0, r_ff.stat};
      end else if (ra == OFS_MASK) begin
        nxt_r.rdata = {26'h0, r_ff.mask};
      end else if (ra == OFS_WAKE) begin
        nxt_r.rdata = {26'h0, r_ff.wake};
      end else begin
        nxt_r.rresp = RESP_SLVERR;
      end
    end

    // Outputs follow the next flags so they line up with the status register
    nxt_r.irq = |(nxt_r.stat & nxt_r.mask);
    nxt_r.wk  = |(nxt_r.stat & nxt_r.wake);
  end

  // State register; the clock is the always-on domain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_ff      <= '0;
      r_ff.ctrl <= RST_CTRL;
      r_ff.stat <= RST_EV;
      r_ff.mask <= RST_EV;
      r_ff.wake <= RST_EV;
      r_ff.sw   <= RST_SW;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Bus handshakes are combinational, data from flops
  always_comb begin
    axi_rsp.awready = !r_ff.aw_got && !r_ff.bvalid;
    axi_rsp.wready  = !r_ff.w_got && !r_ff.bvalid;
    axi_rsp.bvalid  = r_ff.bvalid;
    axi_rsp.bresp   = r_ff.bresp;
    axi_rsp.arready = !r_ff.rvalid;
    axi_rsp.rvalid  = r_ff.rvalid;
    axi_rsp.rdata   = r_ff.rdata;
    axi_rsp.rresp   = r_ff.rresp;
  end

  assign irq      = r_ff.irq;
  assign wake_req = r_ff.wk;

  // Prescaler restarts after each tick
  property p_tick_restart;
    @(posedge clock) disable iff (!rst_n)
      tick |=> (r_ff.pre == '0);
  endproperty
  a_tick_restart: assert property (p_tick_restart)
    else $error("prescaler did not restart after tick");

  // Seconds wrap carries into minutes
  property p_sec_carry;
    @(posedge clock) disable iff (!rst_n)
      tick && !tm_wr && r_ff.tm.sec == SEC_LAST && r_ff.tm.min < MIN_LAST
      |=> r_ff.tm.sec == 6'h00 && r_ff.tm.min == $past(r_ff.tm.min) + 6'h01;
  endproperty
  a_sec_carry: assert property (p_sec_carry)
    else $error("seconds wrap did not carry into minutes");

  // Midnight wraps hours and advances days
  property p_day_carry;
    @(posedge clock) disable iff (!rst_n)
      tick && !tm_wr && r_ff.tm.sec == SEC_LAST && r_ff.tm.min == MIN_LAST &&
      r_ff.tm.hour == HOUR_LAST
      |=> r_ff.tm.hour == 5'h00 && r_ff.tm.day == $past(r_ff.tm.day) + 8'h01;
  endproperty
  a_day_carry: assert property (p_day_carry)
    else $error("hour wrap did not advance day");

  // Time-of-day alarm sets its flag
  property p_alm0;
    @(posedge clock) disable iff (!rst_n)
      alm0_hit |=> r_ff.stat[EV_ALM0];
  endproperty
  a_alm0: assert property (p_alm0)
    else $error("alarm zero flag not set");

  // Day alarm ignores a match with a different day
  property p_alm1_day;
    @(posedge clock) disable iff (!rst_n)
      alm1_hit |-> tn.day == r_ff.alm1.day && r_ff.ctrl[CTL_ALM1_EN];
  endproperty
  a_alm1_day: assert property (p_alm1_day)
    else $error("alarm one matched without day");

  // Stopwatch counts down once per minute
  property p_sw_step;
    @(posedge clock) disable iff (!rst_n)
      min_ev && r_ff.ctrl[CTL_SW_EN] && !sw_wr
      |=> r_ff.sw == $past(r_ff.sw) - 16'h0001;
  endproperty
  a_sw_step: assert property (p_sw_step)
    else $error("stopwatch did not step");

  // Underflow flags and wraps
  property p_sw_under;
    @(posedge clock) disable iff (!rst_n)
      sw_ev && !sw_wr |=> r_ff.stat[EV_SWU] && r_ff.sw == 16'hFFFF;
  endproperty
  a_sw_under: assert property (p_sw_under)
    else $error("stopwatch underflow missed");

  // Seconds flag follows every tick
  property p_sec_flag;
    @(posedge clock) disable iff (!rst_n)
      tick |=> r_ff.stat[EV_SEC];
  endproperty
  a_sec_flag: assert property (p_sec_flag)
    else $error("seconds flag not set");

  // Interrupt tracks enabled flags
  property p_irq;
    @(posedge clock) disable iff (!rst_n)
      irq == |(r_ff.stat & r_ff.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt disagrees with flags");

  // Wakeup tracks wake-enabled flags
  property p_wake;
    @(posedge clock) disable iff (!rst_n)
      wake_req == |(r_ff.stat & r_ff.wake);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wakeup disagrees with flags");

endmodule // wta_rtc

/* design/wta_xtal_sync.sv */
// Brings the crystal pin into the clock domain and flags its rising edges
module wta_xtal_sync
  import wta_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic xtal_in,
  output logic      xtal_rise
);

  // All state of the synchroniser
  typedef struct packed {
    logic s1;    // First stage, read only by s2
    logic s2;    // Second stage
    logic s3;    // Third stage
    logic lvl;   // Accepted level
    logic rise;  // Registered edge strobe
  } wta_sync_state_t;

  wta_sync_state_t sync_ff;   // Current state
  wta_sync_state_t nxt_sync;  // Next state

  // Shift and accept a level once stages two and three agree
  always_comb begin
    nxt_sync      = sync_ff;
    nxt_sync.s1   = xtal_in;
    nxt_sync.s2   = sync_ff.s1;
    nxt_sync.s3   = sync_ff.s2;
    nxt_sync.rise = 1'b0;
    if (sync_ff.s2 == sync_ff.s3) begin
      // One rise per accepted low-to-high change filters a single glitch
      nxt_sync.lvl  = sync_ff.s3;
      nxt_sync.rise = sync_ff.s3 & ~sync_ff.lvl;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign xtal_rise = sync_ff.rise;

endmodule // wta_xtal_sync

/* test/wta_rtc_tb_top.sv */
module wta_rtc_tb_top
  import wta_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // Short prescale: four crystal rises make one second
  localparam int unsigned DIV_SIM = 4;

  logic         clock;            // 125 MHz system clock
  logic         rst_n;            // Synchronous reset, active low
  logic         xtal_in;          // Crystal square wave
  wta_axi_req_t axi_req;          // Bus master side
  wta_axi_rsp_t axi_rsp;          // Bus slave side
  logic         irq;              // Interrupt level
  logic         wake_req;         // Wakeup level
  int           miscompares;      // Mismatches seen
  int           samples_checked;  // Comparisons made
  logic [31:0]  rdat;             // Last read data
  logic [1:0]   resp;             // Last response code
  logic [3:0]   wr_strb;          // Byte lanes for the next write

  wta_rtc #(.XTAL_DIV_P(DIV_SIM)) i_dut (
    .clock    (clock),
    .rst_n    (rst_n),
    .xtal_in  (xtal_in),
    .axi_req  (axi_req),
    .axi_rsp  (axi_rsp),
    .irq      (irq),
    .wake_req (wake_req)
  );

  // Clock generator
  always #4 clock = ~clock;

  // Crystal: four clocks per phase keeps each phase above the sync minimum
  always begin
    repeat (4) @(posedge clock);
    xtal_in <= ~xtal_in;
  end

  // Time word layout: day, hour, minute, second
  function automatic logic [31:0] tw(input logic [7:0] d, input logic [4:0] h,
                                     input logic [5:0] m, input logic [5:0] s);
    return {d, 3'h0, h, 2'h0, m, 2'h0, s};
  endfunction

  // Closing report, the only way out of the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Word compare
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single flag compare
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bus write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clock);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= {24'h000000, a};
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= wr_strb;
    axi_req.bready  <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clock);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    // A lost response is a hang: stop here
    if (!done) begin
      miscompares++;
      test_done();
    end
  endtask

  // Bus read; rready held until the data arrive
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge clock);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= {24'h000000, a};
    axi_req.rready  <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clock);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      miscompares++;
      test_done();
    end
  endtask

  // Poll the time word until it shows the expected value
  task automatic poll(input logic [31:0] exp);
    for (int i = 0; i < 100; i++) begin
      rd(OFS_TIME);
      if (rdat === exp) return;
    end
    // Counters never got there
    miscompares++;
    test_done();
  endtask

  // Reset values, then unmapped accesses refused with no data
  task automatic t_reset();
    rd(OFS_STAT);
    chk_word("stat reset", 32'h00000000, rdat);
    rd(OFS_TIME);
    chk_word("time reset", 32'h00000000, rdat);
    for (int a = 0; a < 4; a++) begin
      rd(8'(OFS_SWCH + 4 * a));
      chk_word("reg reset", 32'h00000000, rdat);
    end
    rd(8'h20);
    chk_word("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk_word("unmapped data", 32'h00000000, rdat);
    wr(8'h24, 32'hFFFFFFFF);
    chk_word("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    $display("test reset done");
  endtask

  // Carry through all counters, plus the day wrap
  task automatic t_carry();
    wr(OFS_STAT, 32'h0000003F);
    chk_word("mapped wr resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    wr(OFS_TIME, tw(8'h05, 5'h17, 6'h3B, 6'h3A));
    poll(tw(8'h06, 5'h00, 6'h00, 6'h00));
    rd(OFS_STAT);
    chk_word("periodic flags", 32'h00000007, rdat & 32'h3F);
    wr(OFS_TIME, tw(8'hFF, 5'h17, 6'h3B, 6'h3B));
    poll(tw(8'h00, 5'h00, 6'h00, 6'h00));
    $display("test carry done");
  endtask

  // Masking, clearing and wakeup selection
  task automatic t_irq();
    wr(OFS_STAT, 32'h0000003F);
    wr(OFS_MASK, 32'h1 << EV_MIN);
    wr(OFS_TIME, tw(8'h00, 5'h00, 6'h00, 6'h3A));
    poll(tw(8'h00, 5'h00, 6'h00, 6'h3B));
    chk_bit("irq masked", 1'b0, irq);
    poll(tw(8'h00, 5'h00, 6'h01, 6'h00));
    chk_bit("irq minute", 1'b1, irq);
    wr(OFS_STAT, 32'h1 << EV_MIN);
    repeat (2) @(posedge clock);
    chk_bit("irq cleared", 1'b0, irq);
    wr(OFS_WAKE, 32'h1 << EV_SEC);
    poll(tw(8'h00, 5'h00, 6'h01, 6'h01));
    repeat (2) @(posedge clock);
    chk_bit("wake second", 1'b1, wake_req);
    wr(OFS_WAKE, 32'h00000000);
    repeat (2) @(posedge clock);
    chk_bit("wake off", 1'b0, wake_req);
    $display("test irq done");
  endtask

  // Time-only alarm, day-and-time alarm, disabled alarm
  task automatic t_alarm();
    wr(OFS_ALM0, tw(8'h09, 5'h01, 6'h02, 6'h04));
    wr(OFS_ALM1, tw(8'h09, 5'h01, 6'h02, 6'h04));
    wr(OFS_CTRL, 32'h00000003);
    wr(OFS_TIME, tw(8'h03, 5'h01, 6'h02, 6'h02));
    wr(OFS_STAT, 32'h0000003F);
    poll(tw(8'h03, 5'h01, 6'h02, 6'h05));
    rd(OFS_STAT);
    chk_word("alarm day ignored", 32'h00000008, rdat & 32'h18);
    wr(OFS_ALM1, tw(8'h03, 5'h01, 6'h02, 6'h07));
    wr(OFS_STAT, 32'h0000003F);
    poll(tw(8'h03, 5'h01, 6'h02, 6'h08));
    rd(OFS_STAT);
    chk_word("alarm day match", 32'h00000010, rdat & 32'h18);
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_ALM0, tw(8'h00, 5'h01, 6'h02, 6'h0A));
    wr(OFS_STAT, 32'h0000003F);
    poll(tw(8'h03, 5'h01, 6'h02, 6'h0B));
    rd(OFS_STAT);
    chk_word("alarm disabled", 32'h00000000, rdat & 32'h18);
    // Only the seconds byte lane may change
    wr_strb = 4'h1;
    wr(OFS_ALM0, 32'hFFFFFF3F);
    wr_strb = 4'hF;
    rd(OFS_ALM0);
    chk_word("alarm byte lane", tw(8'h00, 5'h01, 6'h02, 6'h3F), rdat);
    $display("test alarm done");
  endtask

  // Countdown per minute, then underflow flag and interrupt
  task automatic t_stopwatch();
    wr(OFS_MASK, 32'h1 << EV_SWU);
    wr(OFS_CTRL, 32'h1 << CTL_SW_EN);
    wr(OFS_SWCH, 32'h00000001);
    wr(OFS_STAT, 32'h0000003F);
    wr(OFS_TIME, tw(8'h00, 5'h00, 6'h05, 6'h3A));
    poll(tw(8'h00, 5'h00, 6'h06, 6'h00));
    rd(OFS_SWCH);
    chk_word("stopwatch step", 32'h00000000, rdat);
    rd(OFS_STAT);
    chk_word("no underflow yet", 32'h00000000, rdat & 32'h20);
    wr(OFS_TIME, tw(8'h00, 5'h00, 6'h06, 6'h3A));
    poll(tw(8'h00, 5'h00, 6'h07, 6'h00));
    rd(OFS_SWCH);
    chk_word("stopwatch wrap", 32'h0000FFFF, rdat);
    rd(OFS_STAT);
    chk_word("underflow flag", 32'h00000020, rdat & 32'h20);
    chk_bit("underflow irq", 1'b1, irq);
    $display("test stopwatch done");
  endtask

  // Main sequence
  initial begin
    clock           = 1'b0;
    rst_n           = 1'b0;
    xtal_in         = 1'b0;
    axi_req         = '0;
    wr_strb         = 4'hF;
    miscompares     = 0;
    samples_checked = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_carry();
    t_irq();
    t_alarm();
    t_stopwatch();
    test_done();
  end

endmodule // wta_rtc_tb_top
